// >>> rtl/sfrp_pkg.sv
// shared constants and types of the serial flash read/program sequencer
package sfrp_pkg;
  // ---------------------------------------------------------------
  // timing and geometry
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_PP_NS = 500000; // nominal program time, plain default
  localparam int PP_CYCLES_DEF = (T_PP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W = 24;
  localparam int PAGE_SIZE_DEF = 256;
  localparam int MEM_AW_DEF = 16;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_DOFR = 8'h3b;
  localparam logic [7:0] OP_DIOFR = 8'hbb;
  localparam logic [7:0] OP_QOFR = 8'h6b;
  localparam logic [7:0] OP_QIOFR = 8'heb;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  // program, suspend and resume codes: values arbitrary
  localparam logic [7:0] OP_PP = 8'h10;
  localparam logic [7:0] OP_DIFP = 8'h11;
  localparam logic [7:0] OP_EDIFP = 8'h12;
  localparam logic [7:0] OP_QIFP = 8'h13;
  localparam logic [7:0] OP_EQIFP = 8'h14;
  localparam logic [7:0] OP_SUSP = 8'h15;
  localparam logic [7:0] OP_RESM = 8'h16;
  // ---------------------------------------------------------------
  // register map, fields, reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DUMMY = 4'h4;
  localparam logic [3:0] REG_PROT = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam logic [1:0] PROTO_EXT = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  localparam int CTRL_FAIL_BIT = 2;
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_FLAG_LSB = 8;
  localparam int FLAG_PROT_BIT = 1;
  localparam int FLAG_PSUSP_BIT = 2;
  localparam int FLAG_PROG_BIT = 4;
  localparam int FLAG_SUSP_BIT = 7;
  localparam int PROT_EN_BIT = 16;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [19:0] DUMMY_RST = 20'h88888;
  localparam logic [16:0] PROT_RST = 17'h00000;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {K_NONE, K_READ, K_PROG, K_WREN, K_WRDI, K_SUSP, K_RESM} sfrp_kind_t;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_PDATA, ST_IGNORE} sfrp_state_t;
  typedef struct packed {
    sfrp_kind_t kind;
    logic [2:0] aw;   // address lanes
    logic [2:0] dw;   // data lanes
    logic [2:0] dsel; // dummy field, 0 for none
  } sfrp_cmd_t;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sfrp_lanes_t;
endpackage : sfrp_pkg

// >>> rtl/sfrp_core.sv
// serial flash read and page program sequencer, device side
// What this block does
// - byte addresses are 24 bits wide for reads and programs
// - read address advances by one after each byte shifted out
// - raising select at any point of data output stops the read
// - read codes 03, 0b, 3b, bb, 6b, eb are decoded
// - single-lane protocol: all reads, lane mapping follows the command
// - two-lane protocol: only 0b, 3b, bb, all phases on lanes 1:0
// - four-lane protocol: only 0b, 6b, eb, all phases on lanes 3:0
// - fast reads wait dummy cycles before data, plain read has none
// - a program needs at least one data byte after the address
// - select rising after a valid program starts a self-timed operation
// - bytes past the page end wrap to the start of the same page
// - beyond a page, only the most recent page of bytes is kept
// - short programs change only the addressed bytes of the page
// - busy bit is one during programming, cleared when it finishes
// - write enable latch clears at the end of every started program
// - a running program can be suspended and resumed
// - a timed-out program clears the latch and sets the program-fail flag
// - select not rising on a byte boundary: no program, no flags, latch kept
// - protected sector: no program, latch kept, flag bits 1 and 4 set
// - two-lane program forms only in single-lane and two-lane protocols
// - four-lane program forms only in single-lane and four-lane protocols
// - write enable code 06 is sent alone, select rising right after
//
// Our own choices: the address map and the address-and-strobe port.
module sfrp_core
  import sfrp_pkg::*;
#(
  parameter int PAGE_SIZE = sfrp_pkg::PAGE_SIZE_DEF,
  parameter int MEM_AW = sfrp_pkg::MEM_AW_DEF,
  parameter int PP_CYCLES = sfrp_pkg::PP_CYCLES_DEF
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // serial link pins
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic [3:0] lanes_in,
  output sfrp_pkg::sfrp_lanes_t lane_drv
);
  import sfrp_pkg::*;
  localparam int PW = $clog2(PAGE_SIZE);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic [2:0] lanes_of(input logic [1:0] proto);
    lanes_of = (proto == PROTO_DUAL) ? 3'h2 : ((proto == PROTO_QUAD) ? 3'h4 : 3'h1);
  endfunction : lanes_of

  function automatic logic [7:0] shin8(input logic [7:0] v, input logic [3:0] d,
                                       input logic [2:0] w);
    shin8 = (w == 3'h1) ? {v[6:0], d[0]} : ((w == 3'h2) ? {v[5:0], d[1:0]} : {v[3:0], d});
  endfunction : shin8

  function automatic logic [23:0] shin24(input logic [23:0] v, input logic [3:0] d,
                                         input logic [2:0] w);
    shin24 = (w == 3'h1) ? {v[22:0], d[0]} : ((w == 3'h2) ? {v[21:0], d[1:0]} : {v[19:0], d});
  endfunction : shin24

  function automatic logic [3:0] dummy_of(input logic [19:0] cfg, input logic [2:0] dsel);
    case (dsel)
      3'h1: dummy_of = cfg[3:0];
      3'h2: dummy_of = cfg[7:4];
      3'h3: dummy_of = cfg[11:8];
      3'h4: dummy_of = cfg[15:12];
      3'h5: dummy_of = cfg[19:16];
      default: dummy_of = 4'h0;
    endcase
  endfunction : dummy_of

  // command decode against the active protocol
  function automatic sfrp_cmd_t decode(input logic [7:0] op, input logic [1:0] proto);
    sfrp_cmd_t c;
    logic ext;
    c.kind = K_NONE;
    c.aw = lanes_of(proto);
    c.dw = lanes_of(proto);
    c.dsel = 3'h0;
    ext = (proto == PROTO_EXT);
    case (op)
      OP_READ: if (ext) c = '{K_READ, 3'h1, 3'h1, 3'h0};
      OP_FREAD: c = '{K_READ, c.aw, c.dw, 3'h1};
      OP_DOFR: if (proto != PROTO_QUAD) c = '{K_READ, c.aw, 3'h2, 3'h2};
      OP_DIOFR: if (proto != PROTO_QUAD) c = '{K_READ, 3'h2, 3'h2, 3'h3};
      OP_QOFR: if (proto != PROTO_DUAL) c = '{K_READ, c.aw, 3'h4, 3'h4};
      OP_QIOFR: if (proto != PROTO_DUAL) c = '{K_READ, 3'h4, 3'h4, 3'h5};
      OP_PP: c = '{K_PROG, 3'h1, 3'h1, 3'h0};
      OP_DIFP: if (proto != PROTO_QUAD) c = '{K_PROG, 3'h1, 3'h2, 3'h0};
      OP_EDIFP: if (proto != PROTO_QUAD) c = '{K_PROG, 3'h2, 3'h2, 3'h0};
      OP_QIFP: if (proto != PROTO_DUAL) c = '{K_PROG, 3'h1, 3'h4, 3'h0};
      OP_EQIFP: if (proto != PROTO_DUAL) c = '{K_PROG, 3'h4, 3'h4, 3'h0};
      OP_WREN: c.kind = K_WREN;
      OP_WRDI: c.kind = K_WRDI;
      OP_SUSP: c.kind = K_SUSP;
      OP_RESM: c.kind = K_RESM;
      default: c.kind = K_NONE;
    endcase
    decode = c;
  endfunction : decode

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [7:0] mem [2**MEM_AW];
  logic [7:0] pbuf [PAGE_SIZE];
  logic [PAGE_SIZE-1:0] pvalid_q;
  logic sel_s1, sel_s2, sel_d, sclk_s1, sclk_s2, sclk_d;
  logic [3:0] lanes_s1, lanes_s2;
  sfrp_state_t state_q;
  sfrp_cmd_t cmd_q;
  logic [4:0] bitcnt_q;
  logic [7:0] shift_q, rbyte_q;
  logic [23:0] addr_q;
  logic [3:0] dcnt_q, rcnt_q;
  logic [PW-1:0] pidx_q;
  logic got_byte_q, extra_q;
  logic [2:0] ctrl_q;
  logic [19:0] dummy_q;
  logic [16:0] prot_q;
  logic wel_q, busy_q, susp_q;
  logic [7:0] flags_q;
  logic [31:0] timer_q;
  logic [PW:0] widx_q;
  logic [23:0] pbase_q;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // the sampled link clock is only a data input here; edges come from comparing the second and third stages
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_d <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      lanes_s1 <= 4'h0;
      lanes_s2 <= 4'h0;
    end
    else
    begin
      sel_s1 <= sel_n;
      sel_s2 <= sel_s1;
      sel_d <= sel_s2;
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      lanes_s1 <= lanes_in;
      lanes_s2 <= lanes_s1;
    end
  end

  // edges and per-phase next values
  logic sclk_rise, sclk_fall, sel_rise, cmd_done, rbyte_done, pb_we;
  logic [2:0] cur_w, proto_w;
  logic [4:0] bits_nx;
  logic [7:0] sh_in;
  logic [23:0] addr_nx;
  sfrp_cmd_t dec;
  assign sclk_rise = sclk_s2 & ~sclk_d & ~sel_s2;
  assign sclk_fall = ~sclk_s2 & sclk_d & ~sel_s2;
  assign sel_rise = sel_s2 & ~sel_d;
  assign proto_w = lanes_of(ctrl_q[1:0]);
  assign cur_w = (state_q == ST_CMD) ? proto_w : ((state_q == ST_ADDR) ? cmd_q.aw : cmd_q.dw);
  assign bits_nx = bitcnt_q + {2'h0, cur_w};
  assign sh_in = shin8(shift_q, lanes_s2, cur_w);
  assign addr_nx = shin24(addr_q, lanes_s2, cmd_q.aw);
  assign dec = decode(sh_in, ctrl_q[1:0]);
  assign cmd_done = sclk_rise && (state_q == ST_CMD) && (bits_nx == 5'd8);
  assign rbyte_done = sclk_fall && (state_q == ST_RDATA) && ((rcnt_q + {1'b0, cmd_q.dw}) == 4'h8);
  assign pb_we = sclk_rise && (state_q == ST_PDATA) && (bits_nx == 5'd8);

  // select-rise events; commands with trailing clocks are dropped
  logic alone, prot_hit, prog_start, prog_ok_frame, wren_ev, wrdi_ev, susp_ev, resm_ev;
  assign alone = sel_rise && (state_q == ST_IGNORE) && !extra_q;
  assign wren_ev = alone && (cmd_q.kind == K_WREN);
  assign wrdi_ev = alone && (cmd_q.kind == K_WRDI);
  assign susp_ev = alone && (cmd_q.kind == K_SUSP) && busy_q && !susp_q;
  assign resm_ev = alone && (cmd_q.kind == K_RESM) && susp_q;
  // byte boundary and at least one byte, else nothing happens
  assign prog_ok_frame = sel_rise && (state_q == ST_PDATA) && (bitcnt_q == 5'd0)
                         && got_byte_q && wel_q && !busy_q;
  assign prot_hit = prog_ok_frame && prot_q[PROT_EN_BIT] && (addr_q[23:16] >= prot_q[7:0])
                    && (addr_q[23:16] <= prot_q[15:8]);
  assign prog_start = prog_ok_frame && !prot_hit;

  // ---------------------------------------------------------------
  // serial sequencer
  // ---------------------------------------------------------------
  // one process owns the frame; select high returns it to command phase
  always_ff @(posedge sys_clk)
  begin
    if (reset || sel_s2)
    begin
      if (reset)
      begin
        cmd_q <= '{K_NONE, 3'h1, 3'h1, 3'h0};
        addr_q <= 24'h0;
        pvalid_q <= '0;
        pidx_q <= '0;
      end
      state_q <= ST_CMD;
      bitcnt_q <= 5'd0;
      shift_q <= 8'h0;
      rbyte_q <= 8'h0;
      dcnt_q <= 4'h0;
      rcnt_q <= 4'h0;
      got_byte_q <= 1'b0;
      extra_q <= 1'b0;
    end
    else if (sclk_rise)
    begin
      case (state_q)
        ST_CMD:
        begin
          shift_q <= sh_in;
          bitcnt_q <= (bits_nx == 5'd8) ? 5'd0 : bits_nx;
          if (bits_nx == 5'd8)
          begin
            cmd_q <= dec;
            // reads are refused during a running program unless it is suspended
            if ((dec.kind == K_READ && (!busy_q || susp_q)) || (dec.kind == K_PROG && !busy_q))
              state_q <= ST_ADDR;
            else
              state_q <= ST_IGNORE;
          end
        end
        ST_ADDR:
        begin
          addr_q <= addr_nx;
          bitcnt_q <= (bits_nx == 5'd24) ? 5'd0 : bits_nx;
          if (bits_nx == 5'd24)
          begin
            if (cmd_q.kind == K_PROG)
            begin
              state_q <= ST_PDATA;
              pvalid_q <= '0;
              pidx_q <= addr_nx[PW-1:0];
            end
            else if (dummy_of(dummy_q, cmd_q.dsel) == 4'h0)
            begin
              state_q <= ST_RDATA;
              rbyte_q <= mem[addr_nx[MEM_AW-1:0]];
            end
            else
            begin
              state_q <= ST_DUMMY;
              dcnt_q <= dummy_of(dummy_q, cmd_q.dsel);
            end
          end
        end
        ST_DUMMY:
        begin
          dcnt_q <= dcnt_q - 4'h1;
          if (dcnt_q == 4'h1)
          begin
            state_q <= ST_RDATA;
            rbyte_q <= mem[addr_q[MEM_AW-1:0]];
          end
        end
        ST_PDATA:
        begin
          shift_q <= sh_in;
          bitcnt_q <= (bits_nx == 5'd8) ? 5'd0 : bits_nx;
          if (bits_nx == 5'd8)
          begin
            // index wraps inside the page; later bytes overwrite earlier ones
            pvalid_q[pidx_q] <= 1'b1;
            pidx_q <= pidx_q + 1'b1;
            got_byte_q <= 1'b1;
          end
        end
        ST_IGNORE: extra_q <= 1'b1;
        default: state_q <= state_q;
      endcase
    end
    else if (sclk_fall && state_q == ST_RDATA)
    begin
      // shift out, then fetch the next byte for a continuous stream
      rbyte_q <= rbyte_q << cmd_q.dw;
      rcnt_q <= rcnt_q + {1'b0, cmd_q.dw};
      if (rbyte_done)
      begin
        rcnt_q <= 4'h0;
        addr_q <= addr_q + 24'h1;
        rbyte_q <= mem[addr_q[MEM_AW-1:0] + 1'b1];
      end
    end
  end

  // page buffer, no reset needed: valid bits gate every use
  always_ff @(posedge sys_clk)
  begin
    if (pb_we)
      pbuf[pidx_q] <= sh_in;
  end

  // ---------------------------------------------------------------
  // lane drivers
  // ---------------------------------------------------------------
  // new bits go out on the falling link edge so they are stable at the rise
  always_ff @(posedge sys_clk)
  begin
    if (reset || sel_s2)
      lane_drv <= '{4'h0, 4'h0};
    else if (sclk_fall && state_q == ST_RDATA)
    begin
      case (cmd_q.dw)
        3'h1: lane_drv <= '{{2'h0, rbyte_q[7], 1'b0}, 4'h2};
        3'h2: lane_drv <= '{{2'h0, rbyte_q[7:6]}, 4'h3};
        default: lane_drv <= '{rbyte_q[7:4], 4'hf};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // program engine and status
  // ---------------------------------------------------------------
  logic mem_we, prog_end, prog_fail;
  logic [7:0] flag_set, flag_clr;
  assign mem_we = busy_q && !susp_q && !widx_q[PW] && pvalid_q[widx_q[PW-1:0]]
                  && !ctrl_q[CTRL_FAIL_BIT];
  assign prog_end = busy_q && !susp_q && (timer_q == 32'h1);
  assign prog_fail = prog_end && ctrl_q[CTRL_FAIL_BIT];
  assign flag_set = ({7'h0, prot_hit} << FLAG_PROT_BIT) | ({7'h0, prot_hit} << FLAG_PROG_BIT)
                  | ({7'h0, prog_fail} << FLAG_PROG_BIT) | ({7'h0, susp_ev} << FLAG_PSUSP_BIT)
                  | ({7'h0, susp_ev} << FLAG_SUSP_BIT);
  assign flag_clr = ((reg_wr && reg_addr == REG_STAT) ? reg_wdata[15:8] : 8'h0)
                  | ({7'h0, resm_ev} << FLAG_PSUSP_BIT) | ({7'h0, resm_ev} << FLAG_SUSP_BIT);

  // walks the page buffer into the array during the first cycles of the operation
  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      mem[{pbase_q[MEM_AW-1:PW], widx_q[PW-1:0]}] <= pbuf[widx_q[PW-1:0]];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      susp_q <= 1'b0;
      timer_q <= 32'h0;
      widx_q <= '0;
      pbase_q <= 24'h0;
    end
    else
    begin
      if (prog_start)
      begin
        busy_q <= 1'b1;
        timer_q <= 32'(PP_CYCLES);
        widx_q <= '0;
        pbase_q <= addr_q;
      end
      else if (busy_q && !susp_q)
      begin
        timer_q <= timer_q - 32'h1;
        if (!widx_q[PW])
          widx_q <= widx_q + 1'b1;
        if (prog_end)
          busy_q <= 1'b0;
      end
      if (susp_ev)
        susp_q <= 1'b1;
      else if (resm_ev)
        susp_q <= 1'b0;
      if (prog_end || wrdi_ev)
        wel_q <= 1'b0;
      else if (wren_ev)
        wel_q <= 1'b1;
    end
  end

  // sticky flags; a hardware set beats a software clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags_q <= 8'h0;
    else
      flags_q <= (flags_q & ~flag_clr) | flag_set;
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RST;
      dummy_q <= DUMMY_RST;
      prot_q <= PROT_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL: ctrl_q <= reg_wdata[2:0];
        REG_DUMMY: dummy_q <= reg_wdata[19:0];
        REG_PROT: prot_q <= reg_wdata[16:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk)
  begin
    if (reset || !reg_rd)
      reg_rdata <= 32'h0;
    else
    begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {29'h0, ctrl_q};
        REG_DUMMY: reg_rdata <= {12'h0, dummy_q};
        REG_PROT: reg_rdata <= {15'h0, prot_q};
        REG_STAT: reg_rdata <= {16'h0, flags_q, 6'h0, wel_q, busy_q};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_start_busy;
    @(posedge sys_clk) disable iff (reset) prog_start |=> busy_q [*2];
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("program did not start");

  property p_wel_end;
    @(posedge sys_clk) disable iff (reset) $fell(busy_q) |-> !wel_q && !lane_drv.oe[3];
  endproperty
  a_wel_end: assert property (p_wel_end) else $error("latch not cleared at end");

  property p_fail_flag;
    @(posedge sys_clk) disable iff (reset)
      prog_end && ctrl_q[CTRL_FAIL_BIT] |=> flags_q[FLAG_PROG_BIT] && !wel_q;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("fail flag missing");

  property p_prot;
    @(posedge sys_clk) disable iff (reset)
      prot_hit |=> !busy_q && wel_q && flags_q[FLAG_PROT_BIT] && flags_q[FLAG_PROG_BIT];
  endproperty
  a_prot: assert property (p_prot) else $error("protected program misbehaved");

  property p_addr_inc;
    @(posedge sys_clk) disable iff (reset) rbyte_done |=> addr_q == $past(addr_q) + 24'h1;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("read address not advanced");

  property p_stop;
    @(posedge sys_clk) disable iff (reset) sel_s2 |=> lane_drv.oe == 4'h0 && state_q == ST_CMD;
  endproperty
  a_stop: assert property (p_stop) else $error("read not stopped by select");

  property p_unaligned;
    @(posedge sys_clk) disable iff (reset)
      sel_rise && state_q == ST_PDATA && bitcnt_q != 5'd0 && !busy_q
      |=> !busy_q && wel_q == $past(wel_q) && flags_q == ($past(flags_q) & ~$past(flag_clr));
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("misaligned program acted");

  property p_dual_reject;
    @(posedge sys_clk) disable iff (reset)
      cmd_done && ctrl_q[1:0] == PROTO_DUAL && (sh_in == OP_READ || sh_in == OP_QIOFR)
      |=> state_q == ST_IGNORE;
  endproperty
  a_dual_reject: assert property (p_dual_reject) else $error("bad read accepted");

  property p_wrap;
    @(posedge sys_clk) disable iff (reset) pb_we |=> pidx_q == $past(pidx_q) + 1'b1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("page index not wrapped");

  c_stream: cover property (@(posedge sys_clk) disable iff (reset) rbyte_done ##[1:200] rbyte_done);
  c_prog: cover property (@(posedge sys_clk) disable iff (reset) prog_start);
  c_susp: cover property (@(posedge sys_clk) disable iff (reset) susp_ev);
  c_prot: cover property (@(posedge sys_clk) disable iff (reset) prot_hit);
endmodule : sfrp_core

// >>> tb/sfrp_host.sv
// host link controller model: select, link clock and lanes
module sfrp_host
  import sfrp_pkg::*;
(
  // pacing clock
  input wire logic sys_clk,
  // link pins
  output logic sel_n,
  output logic sclk,
  output logic [3:0] lanes,
  input wire sfrp_pkg::sfrp_lanes_t drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] oe_seen;
  // idle: deselected, clock parked low
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
    lanes = 4'h0;
    oe_seen = 4'h0;
  end
  // one link clock, lanes held across the rising edge
  task automatic pulse(input logic [3:0] v);
    lanes <= v;
    sclk <= 1'b0;
    repeat (5) @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask : pulse
  // msb first, w lanes per edge, top lane carries the msb
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int k = n - w; k >= 0; k -= w)
      pulse(4'((v >> k) & ((1 << w) - 1)));
  endtask : send
  // sample just before the rising edge, host lanes inverted meanwhile
  task automatic recv(output logic [7:0] b, input int w);
    b = 8'h00;
    for (int k = 0; k < 8; k += w)
    begin
      lanes <= ~lanes;
      sclk <= 1'b0;
      repeat (5) @(posedge sys_clk);
      b = (b << w) | 8'((w == 1) ? {3'h0, drv.o[1]} : (drv.o & 4'((1 << w) - 1)));
      oe_seen = oe_seen | drv.oe;
      sclk <= 1'b1;
      repeat (5) @(posedge sys_clk);
    end
  endtask : recv
  task automatic start();
    oe_seen = 4'h0;
    sel_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask : start
  // select rises five cycles after the link clock is parked low
  task automatic stop();
    sclk <= 1'b0;
    repeat (5) @(posedge sys_clk);
    sel_n <= 1'b1;
    lanes <= ~lanes;
    repeat (8) @(posedge sys_clk);
  endtask : stop
endmodule : sfrp_host

// >>> tb/test_serial_flash_read_program.sv
// self-checking bench: read variants, page program, error paths
module test_serial_flash_read_program;
  import sfrp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] p; logic [7:0] op; logic [3:0] aw; logic [3:0] dw;} sfrp_row_t;
  // protocol, code, address lanes, data lanes (0 means refused)
  sfrp_row_t rows [16] = '{20'h00311, 20'h00b11, 20'h03b12, 20'h0bb22, 20'h06b14, 20'h0eb44,
    20'h10b22, 20'h13b22, 20'h1bb22, 20'h10320, 20'h16b20, 20'h20b44, 20'h26b44, 20'h2eb44,
    20'h20340, 20'h2bb40};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, q;
  logic sel_n, sclk;
  logic [3:0] host_lanes, lanes_in;
  logic [15:0] d;
  sfrp_lanes_t lane_drv;
  int err_total = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  // device wins a shared lane while it drives it
  assign lanes_in = (lane_drv.oe & lane_drv.o) | (~lane_drv.oe & host_lanes);
  sfrp_core #(.PP_CYCLES(300)) sfrp_core_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sel_n(sel_n), .sclk(sclk), .lanes_in(lanes_in), .lane_drv(lane_drv));
  sfrp_host sfrp_host_i (.sys_clk(sys_clk), .sel_n(sel_n), .sclk(sclk), .lanes(host_lanes),
    .drv(lane_drv));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one register cycle; read data taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge sys_clk);
  endtask : bus
  // lone single-lane command frame
  task automatic cmd(input logic [7:0] op);
    sfrp_host_i.start();
    sfrp_host_i.send({24'h0, op}, 8, 1);
    sfrp_host_i.stop();
  endtask : cmd
  // write enable frame, then a page program with xb stray bits
  task automatic prog(input logic [23:0] a, input logic [31:0] v, input int n, input int xb);
    cmd(OP_WREN);
    sfrp_host_i.start();
    sfrp_host_i.send({24'h0, OP_PP}, 8, 1);
    sfrp_host_i.send({8'h0, a}, 24, 1);
    sfrp_host_i.send(v, 8 * n + xb, 1);
    sfrp_host_i.stop();
  endtask : prog
  // read two bytes with the lane layout of one table row
  task automatic rdop(input sfrp_row_t r, input logic [23:0] a);
    sfrp_host_i.start();
    sfrp_host_i.send({24'h0, r.op}, 8, (r.p == 4'h0) ? 1 : (r.p == 4'h1) ? 2 : 4);
    sfrp_host_i.send({8'h0, a}, 24, r.aw);
    sfrp_host_i.send(32'h0, (r.op == OP_READ) ? 0 : 2, 1);
    sfrp_host_i.recv(d[15:8], (r.dw == 4'h0) ? 1 : r.dw);
    sfrp_host_i.recv(d[7:0], (r.dw == 4'h0) ? 1 : r.dw);
    sfrp_host_i.stop();
  endtask : rdop
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(1'b0, REG_DUMMY, 32'h0);
    chk("dummy_reset", q, {12'h0, DUMMY_RST});
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, REG_DUMMY, 32'h22222);
    prog(24'h10fe, 32'ha0a1a2a3, 4, 0);
    bus(1'b0, REG_STAT, 32'h0);
    chk("busy", q[0], 32'h1);
    repeat (320) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0);
    chk("program_done", q, 32'h0);
    $display("program test done");
    foreach (rows[i])
    begin
      bus(1'b1, REG_CTRL, {28'h0, rows[i].p});
      rdop(rows[i], 24'h10fe);
      chk("lane_oe", sfrp_host_i.oe_seen, (rows[i].dw == 4'h1) ? 4'h2 : (rows[i].dw == 4'h2) ? 4'h3
        : (rows[i].dw == 4'h4) ? 4'hf : 4'h0);
      if (rows[i].dw != 4'h0)
        chk("read_data", d, 16'ha0a1);
    end
    $display("read table done");
    bus(1'b1, REG_CTRL, 32'h0);
    rdop(rows[1], 24'h1000);
    chk("page_wrap", d, 16'ha2a3);
    prog(24'h0000, 32'h55, 1, 3);
    repeat (20) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0);
    chk("ragged_end", q, 32'h2);
    bus(1'b1, REG_PROT, 32'h10000);
    prog(24'h0000, 32'h55, 1, 0);
    repeat (20) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0);
    chk("protected", q, 32'h1202);
    bus(1'b1, REG_STAT, 32'hff00);
    bus(1'b1, REG_CTRL, 32'h4);
    prog(24'h012000, 32'h5a, 1, 0);
    repeat (320) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0);
    chk("prog_timeout", q, 32'h1000);
    bus(1'b1, REG_STAT, 32'hff00);
    bus(1'b1, REG_CTRL, 32'h0);
    prog(24'h013000, 32'h3c, 1, 0);
    cmd(OP_SUSP);
    repeat (320) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0);
    chk("suspended", q, 32'h8403);
    cmd(OP_RESM);
    repeat (320) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0);
    chk("resumed", q, 32'h0);
    $display("error tests done");
    results();
  end
  // watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    results();
  end
endmodule : test_serial_flash_read_program
